/* File: rtl/mwd_decode.sv */
// Microword decoder with parity halt, condition codes, trap enable and slow-bus start
`timescale 1ns/1ns
module mwd_decode (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mw_valid,
  input wire logic [mwd_pkg::MW_W-1:0] mw_in,
  input wire logic alu_n,
  input wire logic alu_z,
  input wire logic alu_c,
  input wire logic aux_zero,
  input wire logic aux_condition_flag,
  input wire logic [7:0] ibus_data,
  input wire logic [7:0] slow_rdata,
  output mwd_pkg::mwd_fields_s fields,
  output logic fields_valid,
  output logic branch_taken,
  output logic clk_run,
  output logic parity_halt,
  output logic [2:0] cc_flags,
  output logic trap_en,
  output logic trap_ack,
  output logic [7:0] der_rdata,
  output logic [9:0] ls_addr_out,
  output mwd_pkg::mwd_slow_s slow_bus,
  output logic slow_busy
);
  import mwd_pkg::*;

  logic [MW_W-1:0] microword_register;
  logic parity_bad;
  logic step;
  logic hold;
  logic halt_clr;
  logic [2:0] typ;
  logic [8:0] ind_addr;
  logic [3:0] proc_reg;
  logic der_wr_now;
  logic [6:0] dadr;
  logic [7:0] slow_rd_reg;
  logic slow_busy_i;
  logic apb_acc;
  logic [7:0] aoff;
  mwd_fields_s next_fields;
  logic next_taken;

  // Only an even-parity word may execute
  assign parity_bad = ^mw_in;
  assign step = mw_valid && !parity_halt && !hold;
  assign typ = mw_in[TYPE_HI:TYPE_LO];
  assign dadr = mw_in[DADR_HI:DADR_LO];
  assign der_wr_now = step && typ == T_DER && !mw_in[DIR_BIT];
  assign apb_acc = psel && penable && pready;
  assign aoff = paddr[7:0];
  assign halt_clr = apb_acc && pwrite && aoff == A_CTRL && pwdata[CTRL_CLR];

  // All fields come from the one word in parallel, except seq on a conditional jump, which also uses the flags and aux inputs
  always_comb begin
    next_fields = '0;
    next_fields.op = MWD_OP_RD;
    next_fields.seq = MWD_SEQ_NEXT;
    case (typ)
      T_RD0, T_RD1: next_fields.op = MWD_OP_RD;
      T_TXLO, T_TXHI: next_fields.op = MWD_OP_TX;
      T_WRT: next_fields.op = MWD_OP_WRT;
      T_DER: next_fields.op = MWD_OP_DER;
      T_JMP0, T_JMP1: next_fields.op = MWD_OP_JMP;
      default: next_fields.op = MWD_OP_RD;
    endcase
    next_fields.cc_load = mw_in[CC_CLK_BIT];
    next_fields.carry_in = mw_in[CARRY_BIT];
    next_fields.a_addr = mw_in[AADR_HI:AADR_LO];
    next_fields.b_addr = mw_in[BADR_HI:BADR_LO];
    next_fields.alu_src = mw_in[SRC_HI:SRC_LO];
    next_fields.alu_fn = mw_in[FN_HI:FN_LO];
    next_fields.alu_dst = mw_in[DST_HI:DST_LO];
    next_fields.shift_ctl = {mw_in[SHX_BIT], mw_in[1:0]};
    next_fields.ls_addr = mw_in[LSA_HI:LSA_LO];
    next_fields.tx_high = (typ == T_TXHI);
    next_fields.tx_area = mw_in[TXA_HI:TXA_LO];
    next_fields.der_read = mw_in[DIR_BIT];
    next_fields.der_addr = dadr;
    // Literal shares the A address and shift fields, so those are meaningless here
    next_fields.literal = {mw_in[LIT_HI_HI:LIT_HI_LO], mw_in[AADR_HI:AADR_LO], mw_in[0]};
    next_fields.jump_addr = {mw_in[TYPE_LO], mw_in[LSA_HI:LSA_LO], mw_in[JLO_BIT]};
    if (next_fields.op == MWD_OP_JMP) begin
      case (mw_in[COND_HI:COND_LO])
        C_CALL: next_fields.seq = MWD_SEQ_CALL;
        C_POP: next_fields.seq = MWD_SEQ_POPJ;
        default: next_fields.seq = next_taken ? MWD_SEQ_JUMP : MWD_SEQ_NEXT;
      endcase
    end else if (mw_in[RET_BIT]) begin
      next_fields.seq = MWD_SEQ_RET;
    end
  end

  // Negative, zero and carry test the flags held from earlier cycles; the aux conditions use the live inputs
  always_comb begin
    case (mw_in[COND_HI:COND_LO])
      C_NEG: next_taken = cc_flags[2];
      C_ZERO: next_taken = cc_flags[1];
      C_CARRY: next_taken = cc_flags[0];
      C_AUXZ: next_taken = aux_zero;
      C_AUXC: next_taken = aux_condition_flag;
      default: next_taken = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      microword_register <= '0;
      fields <= '0;
      branch_taken <= 1'b0;
    end else if (step && !parity_bad) begin
      microword_register <= mw_in;
      fields <= next_fields;
      branch_taken <= (next_fields.op == MWD_OP_JMP) && next_taken;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fields_valid <= 1'b0;
    end else begin
      fields_valid <= step && !parity_bad;
    end
  end

  // Sticky halt; a new error wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      parity_halt <= 1'b0;
    end else if (mw_valid && !hold && parity_bad) begin
      parity_halt <= 1'b1;
    end else if (halt_clr) begin
      parity_halt <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clk_run <= 1'b0;
    end else begin
      clk_run <= !hold && !(parity_halt || (mw_valid && parity_bad));
    end
  end

  // Flags order: negative, zero, carry
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cc_flags <= 3'h0;
    end else if (step && !parity_bad && mw_in[CC_CLK_BIT]) begin
      cc_flags <= {alu_n, alu_z, alu_c};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trap_en <= 1'b0;
    end else if (step && !parity_bad && typ == T_DER) begin
      if (mw_in[TRAP_HI]) begin
        trap_en <= 1'b1;
      end else if (mw_in[TRAP_LO]) begin
        trap_en <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trap_ack <= 1'b0;
    end else begin
      trap_ack <= step && !parity_bad && (typ == T_TXLO || typ == T_TXHI)
        && mw_in[TXA_HI:TXA_LO] == TXA_SLAVE;
    end
  end

  // Indirect address and process registers loaded by discrete writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ind_addr <= 9'h000;
      proc_reg <= 4'h0;
    end else if (der_wr_now && !parity_bad) begin
      if (dadr == DER_IND_ADDR) begin
        ind_addr <= {mw_in[LSA_LO], ibus_data};
      end
      if (dadr == DER_PROC) begin
        proc_reg <= ibus_data[3:0];
      end
    end
  end

  // Low store address bits: indirect, process segment or direct field
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ls_addr_out <= 10'h000;
    end else if (step && !parity_bad) begin
      case (mw_in[SEG_HI:SEG_LO])
        SEG_PROC: ls_addr_out <= {SEG_PROC, proc_reg, mw_in[LSA_LO+3:LSA_LO]};
        SEG_DIRECT: ls_addr_out <= mw_in[LSA_HI:LSA_LO];
        default: ls_addr_out <= {1'b0, ind_addr};
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      der_rdata <= 8'h00;
    end else if (step && !parity_bad && typ == T_DER && mw_in[DIR_BIT]) begin
      if (dadr == DER_SLOW_RDATA) begin
        der_rdata <= slow_rd_reg;
      end else if (dadr == DER_LITERAL) begin
        der_rdata <= next_fields.literal;
      end else begin
        der_rdata <= 8'h00;
      end
    end
  end

  mwd_slow_ctl u_slow (
    .clk_sys(clk_sys),
    .rst(rst),
    .step(step),
    .start_wr(der_wr_now && !parity_bad && dadr == DER_SLOW_WDATA),
    .start_rd(der_wr_now && !parity_bad && dadr == DER_SLOW_RSTART),
    .dev_addr(ind_addr),
    .wdata(ibus_data),
    .slow_rdata(slow_rdata),
    .bus(slow_bus),
    .rd_reg(slow_rd_reg),
    .busy(slow_busy_i)
  );

  // Busy is already a flip-flop in the controller; a second stage would report a start one cycle late
  assign slow_busy = slow_busy_i;

  // APB slave, no wait states: pready rises in the first access cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable && !pready;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold <= 1'b0;
    end else if (apb_acc && pwrite && aoff == A_CTRL) begin
      hold <= pwdata[CTRL_HOLD];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      case (aoff)
        A_CTRL: prdata <= {30'h0, hold, 1'b0};
        A_STATUS: prdata <= {26'h0, slow_busy, cc_flags, trap_en, parity_halt};
        A_MW_LO: prdata <= microword_register[31:0];
        A_MW_HI: prdata <= {28'h0, microword_register[MW_W-1:32]};
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
      if (paddr[31:8] != 24'h0) begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b1;
      end
    end
  end
endmodule : mwd_decode

/* File: rtl/mwd_pkg.sv */
// Package: microword field layout, opcodes, register map and slow-bus timing
package mwd_pkg;
  localparam int MW_W = 36;
  localparam int PARITY_BIT = 35;
  localparam int TYPE_LO = 5;
  localparam int TYPE_HI = 7;
  localparam int COND_LO = 0;
  localparam int COND_HI = 2;
  localparam int RET_BIT = 2;
  localparam int CC_CLK_BIT = 3;
  localparam int CARRY_BIT = 4;
  localparam int AADR_LO = 8;
  localparam int AADR_HI = 11;
  localparam int BADR_LO = 12;
  localparam int BADR_HI = 15;
  localparam int LSA_LO = 16;
  localparam int LSA_HI = 25;
  localparam int SEG_LO = 24;
  localparam int SEG_HI = 25;
  localparam int TXA_LO = 16;
  localparam int TXA_HI = 17;
  localparam int TRAP_LO = 24;
  localparam int TRAP_HI = 25;
  localparam int DIR_BIT = 23;
  localparam int DADR_LO = 16;
  localparam int DADR_HI = 22;
  localparam int JLO_BIT = 14;
  localparam int SRC_LO = 26;
  localparam int SRC_HI = 28;
  localparam int FN_LO = 29;
  localparam int FN_HI = 31;
  localparam int DST_LO = 32;
  localparam int DST_HI = 34;
  localparam int SHX_BIT = 33;
  localparam int LIT_HI_LO = 16;
  localparam int LIT_HI_HI = 18;

  // Instruction type codes, bits 7:5
  localparam logic [2:0] T_RD0 = 3'h0;
  localparam logic [2:0] T_RD1 = 3'h1;
  localparam logic [2:0] T_TXLO = 3'h2;
  localparam logic [2:0] T_TXHI = 3'h3;
  localparam logic [2:0] T_WRT = 3'h4;
  localparam logic [2:0] T_DER = 3'h5;
  localparam logic [2:0] T_JMP0 = 3'h6;
  localparam logic [2:0] T_JMP1 = 3'h7;

  // Jump conditions, bits 2:0
  localparam logic [2:0] C_NEG = 3'h0;
  localparam logic [2:0] C_ZERO = 3'h1;
  localparam logic [2:0] C_CARRY = 3'h2;
  localparam logic [2:0] C_AUXZ = 3'h3;
  localparam logic [2:0] C_AUXC = 3'h4;
  localparam logic [2:0] C_CALL = 3'h5;
  localparam logic [2:0] C_POP = 3'h6;
  localparam logic [2:0] C_ALWAYS = 3'h7;

  localparam logic [1:0] TXA_SLAVE = 2'h3;
  localparam logic [1:0] SEG_PROC = 2'h2;
  localparam logic [1:0] SEG_DIRECT = 2'h3;

  // Discrete register addresses used by this block
  localparam logic [6:0] DER_IND_ADDR = 7'h10;
  localparam logic [6:0] DER_SLOW_WDATA = 7'h11;
  localparam logic [6:0] DER_SLOW_RSTART = 7'h12;
  localparam logic [6:0] DER_SLOW_RDATA = 7'h13;
  localparam logic [6:0] DER_LITERAL = 7'h14;
  localparam logic [6:0] DER_PROC = 7'h15;

  // Slow access length in microinstructions
  localparam logic [1:0] SLOW_STEPS = 2'h3;

  // APB register map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_MW_LO = 8'h08;
  localparam logic [7:0] A_MW_HI = 8'h0c;
  localparam int CTRL_CLR = 0;
  localparam int CTRL_HOLD = 1;

  typedef enum logic [4:0] {
    MWD_SEQ_NEXT = 5'h01,
    MWD_SEQ_JUMP = 5'h02,
    MWD_SEQ_CALL = 5'h04,
    MWD_SEQ_POPJ = 5'h08,
    MWD_SEQ_RET = 5'h10
  } mwd_seq_e;

  typedef enum logic [4:0] {
    MWD_OP_RD = 5'h01,
    MWD_OP_TX = 5'h02,
    MWD_OP_WRT = 5'h04,
    MWD_OP_DER = 5'h08,
    MWD_OP_JMP = 5'h10
  } mwd_op_e;

  typedef struct packed {
    mwd_op_e op;
    mwd_seq_e seq;
    logic [11:0] jump_addr;
    logic cc_load;
    logic carry_in;
    logic [3:0] a_addr;
    logic [3:0] b_addr;
    logic [2:0] alu_src;
    logic [2:0] alu_fn;
    logic [2:0] alu_dst;
    logic [2:0] shift_ctl;
    logic [9:0] ls_addr;
    logic tx_high;
    logic [1:0] tx_area;
    logic der_read;
    logic [6:0] der_addr;
    logic [7:0] literal;
  } mwd_fields_s;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } mwd_slow_s;
endpackage : mwd_pkg

/* File: rtl/mwd_slow_ctl.sv */
// Slow-bus read/write controller running beside microcode execution
`timescale 1ns/1ns
module mwd_slow_ctl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic step,
  input wire logic start_wr,
  input wire logic start_rd,
  input wire logic [8:0] dev_addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] slow_rdata,
  output mwd_pkg::mwd_slow_s bus,
  output logic [7:0] rd_reg,
  output logic busy
);
  import mwd_pkg::*;

  typedef enum logic [2:0] {
    MWD_SL_IDLE = 3'h1,
    MWD_SL_WR = 3'h2,
    MWD_SL_RD = 3'h4
  } mwd_slst_e;

  mwd_slst_e state;
  mwd_slst_e next_state;
  logic [1:0] cnt;
  logic last;

  // Counted in microinstructions, so the master clock is never held
  assign last = step && (cnt == SLOW_STEPS - 2'h1);

  always_comb begin
    next_state = state;
    case (state)
      MWD_SL_IDLE: begin
        if (start_wr) begin
          next_state = MWD_SL_WR;
        end else if (start_rd) begin
          next_state = MWD_SL_RD;
        end
      end
      MWD_SL_WR, MWD_SL_RD: begin
        if (last) begin
          next_state = MWD_SL_IDLE;
        end
      end
      default: next_state = MWD_SL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= MWD_SL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || state == MWD_SL_IDLE) begin
      cnt <= 2'h0;
    end else if (step) begin
      cnt <= cnt + 2'h1;
    end
  end

  // Device select comes from the indirect address register only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus <= '0;
    end else begin
      if (state == MWD_SL_IDLE && (start_wr || start_rd)) begin
        bus.addr <= dev_addr;
        bus.wdata <= wdata;
      end
      bus.wr <= (next_state == MWD_SL_WR);
      bus.rd <= (next_state == MWD_SL_RD);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_reg <= 8'h00;
    end else if (state == MWD_SL_RD && last) begin
      rd_reg <= slow_rdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state != MWD_SL_IDLE);
    end
  end
endmodule : mwd_slow_ctl

/* File: tb/mwd_decode_properties.sv */
// Checker of microword decode timing, field mapping and slow-bus start
`timescale 1ns/1ns
module mwd_decode_chk
  import mwd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mw_valid,
  input wire logic [mwd_pkg::MW_W-1:0] mw_in,
  input wire logic alu_n,
  input wire logic alu_z,
  input wire logic alu_c,
  input wire mwd_pkg::mwd_fields_s fields,
  input wire logic fields_valid,
  input wire logic clk_run,
  input wire logic parity_halt,
  input wire logic [2:0] cc_flags,
  input wire logic trap_en,
  input wire logic trap_ack,
  input wire mwd_pkg::mwd_slow_s slow_bus,
  input wire logic slow_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic acc;
  // clk_run already folds in hold and halt, so it gates acceptance
  assign acc = clk_run && mw_valid && !(^mw_in);
  sequence s_take;
    acc;
  endsequence
  sequence s_rd_go;
    acc && mw_in[7:5] == T_DER && !mw_in[23] && mw_in[22:16] == DER_SLOW_RSTART && !slow_busy;
  endsequence
  property p_take;
    s_take |=> fields_valid;
  endproperty
  a_take: assert property (p_take) else $error("good word not accepted");
  property p_bad;
    clk_run && mw_valid && (^mw_in) |=> parity_halt && !fields_valid;
  endproperty
  a_bad: assert property (p_bad) else $error("odd parity word not refused");
  property p_halt;
    parity_halt [*2] |-> !clk_run;
  endproperty
  a_halt: assert property (p_halt) else $error("clock runs while halted");
  property p_alu;
    s_take |=> {fields.alu_dst, fields.alu_fn, fields.alu_src, fields.carry_in} == $past({mw_in[34:26], mw_in[4]});
  endproperty
  a_alu: assert property (p_alu) else $error("alu fields wrong");
  property p_jmp;
    acc && mw_in[7:6] == 2'h3 |=> fields.op == MWD_OP_JMP && fields.jump_addr == $past({mw_in[5], mw_in[25:16], mw_in[14]});
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump decode wrong");
  property p_ret;
    acc && mw_in[7:6] != 2'h3 && mw_in[2] |=> fields.seq == MWD_SEQ_RET;
  endproperty
  a_ret: assert property (p_ret) else $error("return not selected");
  property p_cc;
    acc && mw_in[3] |=> cc_flags == $past({alu_n, alu_z, alu_c});
  endproperty
  a_cc: assert property (p_cc) else $error("flags not loaded");
  property p_cc_keep;
    !(acc && mw_in[3]) |=> $stable(cc_flags);
  endproperty
  a_cc_keep: assert property (p_cc_keep) else $error("flags changed");
  property p_ack;
    acc && mw_in[7:6] == 2'h1 && mw_in[17:16] == TXA_SLAVE |=> trap_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("trap ack missing");
  property p_trap;
    acc && mw_in[7:5] == T_DER && mw_in[25:24] != 2'h0 |=> trap_en == $past(mw_in[25]);
  endproperty
  a_trap: assert property (p_trap) else $error("trap enable wrong");
  property p_slow;
    s_rd_go |=> slow_bus.rd && slow_busy && clk_run;
  endproperty
  a_slow: assert property (p_slow) else $error("slow read not started");
endmodule : mwd_decode_chk
bind mwd_decode mwd_decode_chk mwd_decode_chk_i (.clk_sys, .rst, .mw_valid, .mw_in, .alu_n, .alu_z, .alu_c,
  .fields, .fields_valid, .clk_run, .parity_halt, .cc_flags, .trap_en, .trap_ack, .slow_bus, .slow_busy);

/* File: tb/mwd_slow_dev.sv */
// Slow peripheral model answering reads on the slow bus
`timescale 1ns/1ns
module mwd_slow_dev
  import mwd_pkg::*;
(
  input wire logic clk_sys,
  input wire mwd_pkg::mwd_slow_s bus,
  output logic [7:0] rdata
);
  initial rdata = 8'h00;
  // Outside a read the data toggles, so a late capture shows up as wrong data
  always @(posedge clk_sys) begin
    if (bus.rd) begin
      rdata <= bus.addr[7:0] ^ 8'h5a;
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule : mwd_slow_dev

/* File: tb/tb_top.sv */
// Self-checking bench for the microword decoder and slow-bus controller
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t: mismatch", $time); end end
module tb_top;
  import mwd_pkg::*;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, mw_valid = 0, se;
  logic alu_n = 0, alu_z = 0, alu_c = 0, aux_zero = 0, aux_condition_flag = 0;
  logic pready, pslverr, fields_valid, branch_taken, clk_run, parity_halt, trap_en, trap_ack, slow_busy;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [35:0] mw_in = 0, w;
  logic [7:0] ibus_data = 0, slow_rdata, der_rdata;
  logic [2:0] cc_flags, ccm = 0;
  logic [9:0] ls_addr_out;
  mwd_fields_s fields;
  mwd_slow_s slow_bus;
  mwd_op_e ops [8] = '{MWD_OP_RD, MWD_OP_RD, MWD_OP_TX, MWD_OP_TX, MWD_OP_WRT, MWD_OP_DER, MWD_OP_JMP, MWD_OP_JMP};
  int failures = 0, comparisons = 0, ten = 0, i;
  mwd_decode mwd_decode_i (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mw_valid, .mw_in, .alu_n, .alu_z, .alu_c, .aux_zero, .aux_condition_flag, .ibus_data, .slow_rdata, .fields,
    .fields_valid, .branch_taken, .clk_run, .parity_halt, .cc_flags, .trap_en, .trap_ack, .der_rdata, .ls_addr_out,
    .slow_bus, .slow_busy);
  mwd_slow_dev mwd_slow_dev_i (.clk_sys, .bus(slow_bus), .rdata(slow_rdata));
  initial forever #2 clk_sys = ~clk_sys;
  function automatic logic [35:0] par(input logic [35:0] v);
    v[35] = ^v[34:0];
    return v;
  endfunction : par
  function automatic logic [35:0] discrete_register_op(input logic r, input logic [6:0] a);
    return {12'h0, r, a, 8'h0, 3'h5, 5'h0};
  endfunction : discrete_register_op
  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    if (k == 20) begin
      failures++;
      wrap_up;
    end
  endtask : apb
  task automatic step(input logic [35:0] v, input logic [7:0] d);
    logic [2:0] f;
    logic [1:0] a;
    logic [7:0] cv;
    f = 3'($urandom);
    a = 2'($urandom);
    cv = {3'h7, a[0], a[1], ccm[0], ccm[1], ccm[2]};
    @(posedge clk_sys);
    mw_valid <= 1;
    mw_in <= v;
    ibus_data <= d;
    {alu_n, alu_z, alu_c} <= f;
    {aux_zero, aux_condition_flag} <= a;
    @(posedge clk_sys);
    mw_valid <= 0;
    #1;
    if (v[3]) ccm = f;
    if (v[7:5] == T_DER && v[25:24] != 2'h0) ten = int'(v[25]);
    `CHK(fields_valid, 1'b1)
    `CHK(fields.op, ops[v[7:5]])
    `CHK({fields.alu_dst, fields.alu_fn, fields.alu_src}, v[34:26])
    `CHK({fields.carry_in, fields.a_addr, fields.b_addr}, {v[4], v[11:8], v[15:12]})
    `CHK(fields.shift_ctl, {v[33], v[1:0]})
    `CHK(cc_flags, ccm)
    `CHK(trap_en, ten[0])
    `CHK(trap_ack, v[7:6] == 2'h1 && v[17:16] == TXA_SLAVE)
    if (v[7:6] == 2'h3) begin
      `CHK(branch_taken, cv[v[2:0]])
      `CHK(fields.jump_addr, {v[5], v[25:16], v[14]})
    end else begin
      `CHK(fields.seq, v[2] ? MWD_SEQ_RET : MWD_SEQ_NEXT)
    end
    if (v[7:5] < T_DER && v[25:24] == SEG_DIRECT) `CHK(ls_addr_out, v[25:16])
    if (v[7:5] == T_DER) `CHK({fields.der_read, fields.der_addr}, v[23:16])
  endtask : step
  initial begin
    void'($urandom(83));
    repeat (16) @(posedge clk_sys);
    rst <= 0;
    repeat (3) @(posedge clk_sys);
    apb(0, A_STATUS, 0);
    `CHK(rd, 32'h0)
    apb(0, 32'h20, 0);
    `CHK({se, rd}, {1'b1, 32'h0})
    for (i = 0; i < 128; i++) begin
      w = {4'($urandom), 32'($urandom)};
      w[7:5] = 3'(i);
      w[2:0] = 3'(i / 8);
      step(par(w), 8'($urandom));
    end
    $display("test decode done");
    repeat (3) step(par(36'h0), 8'h00);
    step(par(discrete_register_op(0, DER_IND_ADDR)), 8'hc3);
    step(par(discrete_register_op(0, DER_SLOW_WDATA)), 8'h3c);
    `CHK({slow_bus.wr, slow_bus.addr, slow_bus.wdata, slow_busy}, {1'b1, 9'h0c3, 8'h3c, 1'b1})
    repeat (3) step(par(36'h0), 8'h00);
    step(par(discrete_register_op(0, DER_SLOW_RSTART)), 8'h00);
    `CHK(slow_bus.rd, 1'b1)
    repeat (3) step(par(36'h0), 8'h00);
    step(par(discrete_register_op(1, DER_SLOW_RDATA)), 8'h00);
    `CHK(der_rdata, 8'hc3 ^ 8'h5a)
    step(par(discrete_register_op(1, DER_LITERAL) | 36'h0a01), 8'h00);
    `CHK(der_rdata, 8'h95)
    $display("test slow bus done");
    @(posedge clk_sys);
    mw_valid <= 1;
    mw_in <= par(36'h0) ^ 36'h800000000;
    @(posedge clk_sys);
    mw_valid <= 0;
    #1;
    `CHK({parity_halt, fields_valid}, 2'h2)
    repeat (2) @(posedge clk_sys);
    `CHK(clk_run, 1'b0)
    apb(1, A_CTRL, 32'h1);
    for (i = 0; i < 20 && clk_run !== 1'b1; i++) @(posedge clk_sys);
    `CHK(clk_run, 1'b1)
    apb(0, A_STATUS, 0);
    `CHK(rd[0], 1'b0)
    step(par(36'h8), 8'h00);
    apb(1, A_CTRL, 32'h2);
    repeat (2) @(posedge clk_sys);
    `CHK(clk_run, 1'b0)
    apb(1, A_CTRL, 32'h0);
    $display("test halt done");
    wrap_up;
  end
endmodule : tb_top
